// [rpq_pkg.sv]
package rpq_pkg;
  // clock rate and period
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  // nominal delays in ns, as printed
  localparam int unsigned ARR_DELAY_NS   = 50;
  localparam int unsigned NARROW_HOLD_NS = 400;
  localparam int unsigned WIDE_HOLD_NS   = 5000;
  localparam int unsigned QUAL_DELAY_NS  = 500;
  localparam int unsigned NARROW_MIN_NS  = 600;
  localparam int unsigned WIDE_MIN_NS    = 4500;
  // cycle counts, rounded to nearest cycle, with no lower clamp
  localparam int unsigned ARR_DELAY_CYC   = (ARR_DELAY_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int unsigned NARROW_HOLD_CYC = (NARROW_HOLD_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int unsigned WIDE_HOLD_CYC   = (WIDE_HOLD_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int unsigned QUAL_DELAY_CYC  = (QUAL_DELAY_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int unsigned NARROW_MIN_CYC  = (NARROW_MIN_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int unsigned WIDE_MIN_CYC    = (WIDE_MIN_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  // counter width, enough for the longest count (500)
  localparam int unsigned CNT_W = 10;
  // reset values
  localparam logic        HOLD_RST   = 1'b0;
  localparam logic        ACCEPT_RST = 1'b1;
  // receiver operating modes
  typedef enum logic [2:0] {
    RPQ_MODE_NORMAL  = 3'b001,
    RPQ_MODE_RF_CAL  = 3'b010,
    RPQ_MODE_IF_CAL  = 3'b100
  } rpq_mode_type;
endpackage : rpq_pkg

// [rpq_link_if.sv]
`timescale 1ns/10ps
// signals between the qualifier and the cycle timing logic
interface rpq_link_if;
  logic raw_threshold;       // ungated threshold, to cycle timing
  logic processing_busy_n;   // low while a pulse is processed
  logic hold_clear_n;        // low pulse clears the hold
  logic cal_hold_set_n;      // low pulse sets the hold in calibration
  logic freq_out_of_range;   // frequency outside window
  logic narrow_accept;       // narrow width test result
  logic wide_accept;         // wide width test result
  logic amplitude_reset_n;   // low resets the log video peak detector
  logic pulse_valid;         // one-cycle: width results settled
  modport device (
    output raw_threshold, freq_out_of_range, narrow_accept, wide_accept, pulse_valid,
    input  processing_busy_n, hold_clear_n, cal_hold_set_n, amplitude_reset_n
  );
  modport cycle (
    input  raw_threshold, freq_out_of_range, narrow_accept, wide_accept, pulse_valid,
    output processing_busy_n, hold_clear_n, cal_hold_set_n, amplitude_reset_n
  );
endinterface : rpq_link_if

// [rpq_qualifier.sv]
// What this block does
// RQ1 - block threshold on enable, busy, blanking
// RQ2 - threshold only in normal mode
// RQ3 - send ungated raw threshold to cycle logic
// RQ4 - latch gated threshold for detector, 95 percent
// RQ5 - detector threshold delayed 50 ns
// RQ6 - narrow mode: hold 400 ns after 95 percent
// RQ7 - wide mode: hold 5 us after latch
// RQ8 - hold cleared by hold-clear strobe
// RQ9 - calibration set strobe sets the hold
// RQ10 - qualifier strobe 500 ns after 95 percent
// RQ11 - two hold gates from hold timing
// RQ12 - forward frequency out-of-range flag
// RQ13 - narrow: 600 ns width test on half-amplitude
// RQ14 - narrow mode forces wide accept high
// RQ15 - wide: 4.5 us test on raw threshold
// RQ16 - wide mode forces narrow accept high
// RQ17 - cycle logic rejects on zero accept
// RQ18 - end-of-hold reset from amplitude reset
// RQ19 - delays are restartable clock counters
// RQ20 - both or neither mode: accepts forced high
`timescale 1ns/10ps
module rpq_qualifier (
  input  wire logic                  ref_clk_i,               // system clock
  input  wire logic                  rst_i,                   // async, active high
  rpq_link_if.device                 link,                    // cycle timing side
  input  wire logic                  threshold_cmp_i,         // minimum threshold comparator
  input  wire logic                  point95_i,               // 95 percent point comparator
  input  wire logic                  half_amp_i,              // half-amplitude pulse present
  input  wire logic                  freq_cmp_i,              // window comparator output
  input  wire logic                  host_processing_enable_i, // host enable, high active
  input  wire logic                  receiver_blank_n_i,      // low while blanked
  input  wire logic                  narrow_mode_n_i,         // low selects narrow
  input  wire logic                  wide_mode_n_i,           // low selects wide
  input  wire rpq_pkg::rpq_mode_type mode_i,                  // operating mode
  output logic                       latched_threshold_o,     // latched threshold
  output logic                       arrival_threshold_o,     // delayed, to arrival detector
  output logic                       hold_request_o,          // hold request
  output logic                       hold_gate_phase_freq_o,  // hold gate, phase/freq
  output logic                       hold_gate_log_video_o,   // hold gate, log video
  output logic                       qualifier_strobe_o,      // one-cycle qual sample strobe
  output logic                       end_of_hold_reset_o      // peak detector reset
);

  // three-stage synchronisers for pin inputs
  logic [2:0] thr_sync_reg;   // threshold comparator
  logic [2:0] p95_sync_reg;   // 95 percent comparator
  logic [2:0] half_sync_reg;  // half-amplitude
  logic [2:0] freq_sync_reg;  // frequency comparator
  logic       thr_reg;        // filtered levels
  logic       p95_reg;
  logic       half_reg;
  logic       freq_reg;

  // timers
  logic [rpq_pkg::CNT_W-1:0] arrival_cnt_reg; // detector delay
  logic [rpq_pkg::CNT_W-1:0] hold_cnt_reg;   // hold delay
  logic [rpq_pkg::CNT_W-1:0] qual_cnt_reg;   // qualifier delay
  logic [rpq_pkg::CNT_W-1:0] width_cnt_reg;  // width test
  logic                      hold_run_reg;
  logic                      qual_run_reg;
  logic                      width_run_reg;
  logic                      p95_d_reg;      // for edge detect
  logic                      half_d_reg;
  logic                      lth_d_reg;
  logic                      narrow_accept_reg;
  logic                      wide_accept_reg;
  logic                      pulse_valid_reg;
  logic                      gated_thr;
  logic                      narrow_sel;
  logic                      wide_sel;

  // filtered level changes once stages two and three agree
  function automatic logic agree(input logic [2:0] s, input logic prev);
    agree = (s[1] == s[2]) ? s[2] : prev;
  endfunction : agree

  // synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      thr_sync_reg  <= 3'h0;
      p95_sync_reg  <= 3'h0;
      half_sync_reg <= 3'h0;
      freq_sync_reg <= 3'h0;
      thr_reg       <= 1'b0;
      p95_reg       <= 1'b0;
      half_reg      <= 1'b0;
      freq_reg      <= 1'b0;
    end else begin
      thr_sync_reg  <= {thr_sync_reg[1:0], threshold_cmp_i};
      p95_sync_reg  <= {p95_sync_reg[1:0], point95_i};
      half_sync_reg <= {half_sync_reg[1:0], half_amp_i};
      freq_sync_reg <= {freq_sync_reg[1:0], freq_cmp_i};
      thr_reg       <= agree(thr_sync_reg, thr_reg);
      p95_reg       <= agree(p95_sync_reg, p95_reg);
      half_reg      <= agree(half_sync_reg, half_reg);
      freq_reg      <= agree(freq_sync_reg, freq_reg);
    end
  end

  // mode decode; both or neither selects no width test
  assign narrow_sel = !narrow_mode_n_i && wide_mode_n_i;   // see RQ20
  assign wide_sel   = !wide_mode_n_i && narrow_mode_n_i;   // see RQ20

  // gating of the threshold by controls and mode
  assign gated_thr = thr_reg && host_processing_enable_i && link.processing_busy_n
                     && receiver_blank_n_i                 // see RQ1
                     && (mode_i == rpq_pkg::RPQ_MODE_NORMAL); // see RQ2

  assign link.raw_threshold     = thr_reg;                 // see RQ3
  assign link.freq_out_of_range = freq_reg;                // see RQ12

  // latched threshold: set by gated threshold, dropped when raw ends
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      latched_threshold_o <= 1'b0;
    end else if (gated_thr) begin
      latched_threshold_o <= 1'b1;                         // see RQ4
    end else if (!thr_reg) begin
      latched_threshold_o <= 1'b0;
    end
  end

  // edge history
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      p95_d_reg  <= 1'b0;
      half_d_reg <= 1'b0;
      lth_d_reg  <= 1'b0;
    end else begin
      p95_d_reg  <= p95_reg && latched_threshold_o;
      half_d_reg <= half_reg;
      lth_d_reg  <= latched_threshold_o;
    end
  end

  // detector threshold: high once latch held for the delay
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      arrival_cnt_reg     <= '0;
      arrival_threshold_o <= 1'b0;
    end else if (!latched_threshold_o) begin
      arrival_cnt_reg     <= '0;
      arrival_threshold_o <= 1'b0;
    end else if (arrival_cnt_reg == rpq_pkg::CNT_W'(rpq_pkg::ARR_DELAY_CYC - 1)) begin
      arrival_threshold_o <= 1'b1;                         // see RQ5
    end else begin
      arrival_cnt_reg <= arrival_cnt_reg + 1'b1;
    end
  end

  // hold timer: 95 percent edge in narrow, latch edge in wide
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_cnt_reg   <= '0;
      hold_run_reg   <= 1'b0;
      hold_request_o <= rpq_pkg::HOLD_RST;
    end else begin
      if (narrow_sel && p95_reg && latched_threshold_o && !p95_d_reg) begin
        hold_cnt_reg <= rpq_pkg::CNT_W'(1);                // see RQ19
        hold_run_reg <= 1'b1;                              // see RQ6
      end else if (wide_sel && latched_threshold_o && !lth_d_reg) begin
        hold_cnt_reg <= rpq_pkg::CNT_W'(1);               // start edge is the first cycle the latch reads high
        hold_run_reg <= 1'b1;                              // see RQ7
      end else if (hold_run_reg) begin
        hold_cnt_reg <= hold_cnt_reg + 1'b1;
        if (hold_cnt_reg == rpq_pkg::CNT_W'((narrow_sel ? rpq_pkg::NARROW_HOLD_CYC
                                             : rpq_pkg::WIDE_HOLD_CYC) - 1)) begin
          hold_run_reg <= 1'b0;
        end
      end
      // set beats clear
      if (!link.cal_hold_set_n) begin
        hold_request_o <= 1'b1;                            // see RQ9
      end else if (hold_run_reg && hold_cnt_reg == rpq_pkg::CNT_W'((narrow_sel
                   ? rpq_pkg::NARROW_HOLD_CYC : rpq_pkg::WIDE_HOLD_CYC) - 1)) begin
        hold_request_o <= 1'b1;
      end else if (!link.hold_clear_n) begin
        hold_request_o <= 1'b0;                            // see RQ8
      end
    end
  end

  // both gates follow the hold, registered
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_gate_phase_freq_o <= 1'b0;
      hold_gate_log_video_o  <= 1'b0;
    end else begin
      hold_gate_phase_freq_o <= hold_request_o;            // see RQ11
      hold_gate_log_video_o  <= hold_request_o;            // see RQ11
    end
  end

  // qualifier strobe, later than the hold in narrow mode but earlier than it in wide mode
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      qual_cnt_reg       <= '0;
      qual_run_reg       <= 1'b0;
      qualifier_strobe_o <= 1'b0;
    end else begin
      qualifier_strobe_o <= 1'b0;
      if (p95_reg && latched_threshold_o && !p95_d_reg) begin
        qual_cnt_reg <= rpq_pkg::CNT_W'(1);               // see RQ19
        qual_run_reg <= 1'b1;
      end else if (qual_run_reg) begin
        qual_cnt_reg <= qual_cnt_reg + 1'b1;
        if (qual_cnt_reg == rpq_pkg::CNT_W'(rpq_pkg::QUAL_DELAY_CYC - 1)) begin
          qual_run_reg       <= 1'b0;
          qualifier_strobe_o <= 1'b1;                      // see RQ10
        end
      end
    end
  end

  // width tests; unused flag forced to accept
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      width_cnt_reg     <= '0;
      width_run_reg     <= 1'b0;
      narrow_accept_reg <= rpq_pkg::ACCEPT_RST;
      wide_accept_reg   <= rpq_pkg::ACCEPT_RST;
      pulse_valid_reg   <= 1'b0;
    end else begin
      pulse_valid_reg <= 1'b0;
      if (!narrow_sel && !wide_sel) begin
        width_run_reg     <= 1'b0;
        narrow_accept_reg <= 1'b1;                         // see RQ20
        wide_accept_reg   <= 1'b1;
      end else if (narrow_sel) begin
        wide_accept_reg <= 1'b1;                           // see RQ14
        if (half_reg && !half_d_reg) begin
          width_cnt_reg     <= rpq_pkg::CNT_W'(1);        // see RQ19
          width_run_reg     <= 1'b1;
          narrow_accept_reg <= 1'b0;
        end else if (width_run_reg) begin
          width_cnt_reg <= width_cnt_reg + 1'b1;
          if (width_cnt_reg == rpq_pkg::CNT_W'(rpq_pkg::NARROW_MIN_CYC - 1)) begin
            width_run_reg     <= 1'b0;
            narrow_accept_reg <= half_reg;                 // see RQ13
            pulse_valid_reg   <= 1'b1;
          end
        end
      end else begin
        narrow_accept_reg <= 1'b1;                         // see RQ16
        if (latched_threshold_o && !lth_d_reg) begin
          width_cnt_reg   <= rpq_pkg::CNT_W'(1);          // see RQ19
          width_run_reg   <= 1'b1;
          wide_accept_reg <= 1'b0;
        end else if (width_run_reg) begin
          width_cnt_reg <= width_cnt_reg + 1'b1;
          if (width_cnt_reg == rpq_pkg::CNT_W'(rpq_pkg::WIDE_MIN_CYC - 1)) begin
            width_run_reg   <= 1'b0;
            wide_accept_reg <= thr_reg;                    // see RQ15
            pulse_valid_reg <= 1'b1;
          end
        end
      end
    end
  end

  assign link.narrow_accept = narrow_accept_reg;
  assign link.wide_accept   = wide_accept_reg;
  assign link.pulse_valid   = pulse_valid_reg;

  // peak detector reset follows the low amplitude reset
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      end_of_hold_reset_o <= 1'b0;
    end else begin
      end_of_hold_reset_o <= !link.amplitude_reset_n;      // see RQ18
    end
  end

endmodule : rpq_qualifier

// [rpq_cycle.sv]
`timescale 1ns/10ps
// cycle timing end: accepts or rejects each pulse
module rpq_cycle (
  input  wire logic ref_clk_i,          // system clock
  input  wire logic rst_i,              // async, active high
  rpq_link_if.cycle link,               // qualifier side
  input  wire logic freq_window_mode_i, // use frequency window
  input  wire logic cal_mode_i,         // calibration mode active
  input  wire logic settle_done_i,      // receiver settling timed out, pulse
  input  wire logic process_done_i,     // processing complete, pulse
  output logic      pulse_accepted_o,   // one-cycle accept
  output logic      pulse_rejected_o    // one-cycle reject
);

  logic busy_reg;       // a pulse is being processed
  logic clear_n_reg;
  logic cal_set_n_reg;
  logic amp_rst_n_reg;

  // busy from first raw threshold until done or reject
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_reg         <= 1'b0;
      pulse_accepted_o <= 1'b0;
      pulse_rejected_o <= 1'b0;
    end else begin
      pulse_accepted_o <= 1'b0;
      pulse_rejected_o <= 1'b0;
      if (link.pulse_valid && busy_reg) begin
        if (!link.narrow_accept || !link.wide_accept
            || (freq_window_mode_i && link.freq_out_of_range)) begin // see RQ17 see RQ12
          pulse_rejected_o <= 1'b1;
          busy_reg         <= 1'b0;
        end else begin
          pulse_accepted_o <= 1'b1;
        end
      end else if (process_done_i) begin
        busy_reg <= 1'b0;
      end else if (link.raw_threshold) begin
        busy_reg <= 1'b1;
      end
    end
  end

  // strobes to the qualifier, one cycle each
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clear_n_reg   <= 1'b1;
      cal_set_n_reg <= 1'b1;
      amp_rst_n_reg <= 1'b1;
    end else begin
      clear_n_reg   <= !(process_done_i || pulse_rejected_o);      // see RQ8
      cal_set_n_reg <= !(cal_mode_i && settle_done_i);             // see RQ9
      amp_rst_n_reg <= !process_done_i;
    end
  end

  assign link.processing_busy_n = !busy_reg;
  assign link.hold_clear_n      = clear_n_reg;
  assign link.cal_hold_set_n    = cal_set_n_reg;
  assign link.amplitude_reset_n = amp_rst_n_reg;

endmodule : rpq_cycle

// [rpq_link_properties.sv]
`timescale 1ns/10ps
// timing checks on the link and the qualifier outputs
module rpq_link_properties (
  input wire logic ref_clk_i,              // system clock
  input wire logic rst_i,                  // async, active high
  input wire logic hold_clear_n,           // clear strobe, low
  input wire logic cal_hold_set_n,         // calibration set strobe, low
  input wire logic narrow_accept,          // narrow width result
  input wire logic wide_accept,            // wide width result
  input wire logic amplitude_reset_n,      // peak detector reset, low
  input wire logic pulse_valid,            // width result settled
  input wire logic narrow_mode_n_i,        // low selects narrow
  input wire logic wide_mode_n_i,          // low selects wide
  input wire logic latched_threshold_o,    // latched threshold
  input wire logic arrival_threshold_o,    // delayed threshold
  input wire logic hold_request_o,         // hold request
  input wire logic hold_gate_phase_freq_o, // phase/freq gate
  input wire logic hold_gate_log_video_o,  // log video gate
  input wire logic qualifier_strobe_o,     // qual sample strobe
  input wire logic end_of_hold_reset_o     // peak detector reset out
);
  localparam int WIDE_T = 450; // wide width test instant, cycles
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // wide test starts on latch rise only while wide alone is selected
  sequence wide_start;
    $rose(latched_threshold_o) && !wide_mode_n_i && narrow_mode_n_i;
  endsequence
  // latch that stays up for the whole delay
  sequence latch_held;
    $rose(latched_threshold_o) ##1 latched_threshold_o [*4];
  endsequence
  wide_test_a: assert property (wide_start |-> ##[WIDE_T:WIDE_T] pulse_valid)
    else $error("wide width test not at its instant");
  arrival_delay_a: assert property (latch_held |=> arrival_threshold_o)
    else $error("detector threshold late");
  arrival_early_a: assert property ($rose(latched_threshold_o) |-> !arrival_threshold_o [*5])
    else $error("detector threshold early");
  gate_pair_a: assert property ((hold_gate_phase_freq_o == hold_gate_log_video_o)
    && (hold_gate_phase_freq_o == $past(hold_request_o))) else $error("hold gates off");
  hold_clear_a: assert property (!hold_clear_n && cal_hold_set_n |=> !hold_request_o)
    else $error("hold not cleared");
  cal_set_a: assert property (!cal_hold_set_n |=> hold_request_o)
    else $error("hold not set by calibration strobe");
  eoh_reset_a: assert property (end_of_hold_reset_o == !$past(amplitude_reset_n))
    else $error("end of hold reset wrong");
  narrow_force_a: assert property ((!narrow_mode_n_i && wide_mode_n_i) [*2] |-> wide_accept)
    else $error("wide accept not forced");
  wide_force_a: assert property ((narrow_mode_n_i && !wide_mode_n_i) [*2] |-> narrow_accept)
    else $error("narrow accept not forced");
  both_force_a: assert property ((narrow_mode_n_i == wide_mode_n_i) [*2]
    |-> narrow_accept && wide_accept && !pulse_valid) else $error("bad select not forced");
  strobe_once_a: assert property (qualifier_strobe_o |=> !qualifier_strobe_o)
    else $error("qualifier strobe too long");
endmodule : rpq_link_properties

// [tb.sv]
`timescale 1ns/10ps
// both ends joined by the link, driven from their user sides
module tb;
  logic ref_clk_i = 1'b0;             // 100 MHz clock
  logic rst_i     = 1'b1;             // reset, held 2 cycles
  logic thr, p95, half, fcmp;         // comparator pins
  logic en, blank_n, nar_n, wid_n;    // gating and selects
  logic fwin, cal, settle, done;      // cycle end controls
  rpq_pkg::rpq_mode_type mode;        // operating mode
  logic lat, arr, hold, gpf, glv, qs, eoh, acc, rej;
  logic [3:0] mon;                    // watched flags by index
  int n_mismatch = 0;
  int check_count = 0;
  int n_acc = 0, n_rej = 0, n_pv = 0; // event tallies
  rpq_link_if link ();
  rpq_qualifier i_rpq_qualifier (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link),
    .threshold_cmp_i(thr), .point95_i(p95), .half_amp_i(half), .freq_cmp_i(fcmp),
    .host_processing_enable_i(en), .receiver_blank_n_i(blank_n), .narrow_mode_n_i(nar_n),
    .wide_mode_n_i(wid_n), .mode_i(mode), .latched_threshold_o(lat), .arrival_threshold_o(arr),
    .hold_request_o(hold), .hold_gate_phase_freq_o(gpf), .hold_gate_log_video_o(glv),
    .qualifier_strobe_o(qs), .end_of_hold_reset_o(eoh));
  rpq_cycle i_rpq_cycle (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link),
    .freq_window_mode_i(fwin), .cal_mode_i(cal), .settle_done_i(settle),
    .process_done_i(done), .pulse_accepted_o(acc), .pulse_rejected_o(rej));
  rpq_link_properties i_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .hold_clear_n(link.hold_clear_n), .cal_hold_set_n(link.cal_hold_set_n),
    .narrow_accept(link.narrow_accept), .wide_accept(link.wide_accept),
    .amplitude_reset_n(link.amplitude_reset_n), .pulse_valid(link.pulse_valid),
    .narrow_mode_n_i(nar_n), .wide_mode_n_i(wid_n), .latched_threshold_o(lat),
    .arrival_threshold_o(arr), .hold_request_o(hold), .hold_gate_phase_freq_o(gpf),
    .hold_gate_log_video_o(glv), .qualifier_strobe_o(qs), .end_of_hold_reset_o(eoh));
  assign mon = {link.pulse_valid, qs, hold, lat};
  always #5 ref_clk_i = ~ref_clk_i;
  // one-cycle pulses are tallied so scenarios see them late
  always @(posedge ref_clk_i) begin
    if (acc === 1'b1) n_acc++;
    if (rej === 1'b1) n_rej++;
    if (link.pulse_valid === 1'b1) n_pv++;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // inputs move 1 ns after the edge, never on it
  task step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : step
  // bounded wait for a flag; n returns the cycles spent
  task wait_hi(input int i, input int lim, output int n);
    n = 0;
    while (mon[i] !== 1'b1 && n < lim) begin
      step(1);
      n++;
    end
    chk(mon[i], 1'h1);
  endtask : wait_hi
  task pulse_up;
    thr = 1'b1;
    half = 1'b1;
    step(2);
    p95 = 1'b1;
  endtask : pulse_up
  // waits out every timer, so a late expiry cannot beat the clear
  task finish_pulse;
    {thr, half, p95, fcmp} = 4'h0;
    step(60);
    done = 1'b1;
    step(1);
    done = 1'b0;
    step(1);
    chk(eoh, 1'h1);
    step(5);
    chk({hold, gpf, glv}, 3'h0);
  endtask : finish_pulse
  task t_gate;
    for (int i = 0; i < 5; i++) begin
      en = (i != 2);
      blank_n = (i != 3);
      mode = (i == 4) ? rpq_pkg::RPQ_MODE_IF_CAL : rpq_pkg::RPQ_MODE_NORMAL;
      thr = 1'b1;
      step(10);
      chk(link.raw_threshold, 1'h1);
      chk(lat, (i == 0));
      thr = 1'b0;
      step(10);
      // busy left by the first pulse blocks the second; later ones start idle
      if (i != 0) begin
        done = 1'b1;
        step(1);
        done = 1'b0;
        step(2);
      end
    end
    {en, blank_n} = 2'h3;
    mode = rpq_pkg::RPQ_MODE_NORMAL;
  endtask : t_gate
  task t_narrow_ok;
    int n, a0;
    a0 = n_acc;
    pulse_up();
    wait_hi(1, 100, n);
    wait_hi(2, 30, n);
    chk(n, 16'h000A);
    wait_hi(3, 40, n);
    chk({link.narrow_accept, link.wide_accept}, 2'h3);
    step(3);
    chk(n_acc - a0, 16'h0001);
    chk(gpf & glv, 1'h1);
    finish_pulse();
  endtask : t_narrow_ok
  task t_narrow_short;
    int n, r0;
    r0 = n_rej;
    pulse_up();
    step(18);
    {thr, half, p95} = 3'h0;
    wait_hi(3, 80, n);
    chk(link.narrow_accept, 1'h0);
    step(3);
    chk(n_rej - r0, 16'h0001);
    finish_pulse();
  endtask : t_narrow_short
  task t_oor;
    int n, r0;
    r0 = n_rej;
    {fwin, fcmp} = 2'h3;
    pulse_up();
    wait_hi(3, 100, n);
    chk(link.freq_out_of_range, 1'h1);
    step(3);
    chk(n_rej - r0, 16'h0001);
    finish_pulse();
    fwin = 1'b0;
  endtask : t_oor
  task t_wide_ok;
    int n;
    {nar_n, wid_n} = 2'h2;
    thr = 1'b1;
    wait_hi(0, 10, n);
    step(4);
    chk(arr, 1'h0);
    step(1);
    chk(arr, 1'h1);
    wait_hi(3, 500, n);
    chk(n + 5, 16'h01C2);
    chk({link.narrow_accept, link.wide_accept}, 2'h3);
    wait_hi(1, 100, n);
    chk(n, 16'h0032);
    step(1);
    chk(gpf & glv, 1'h1);
    finish_pulse();
  endtask : t_wide_ok
  task t_wide_short;
    int n, r0;
    r0 = n_rej;
    thr = 1'b1;
    step(100);
    thr = 1'b0;
    wait_hi(3, 500, n);
    chk(link.wide_accept, 1'h0);
    step(3);
    chk(n_rej - r0, 16'h0001);
    finish_pulse();
  endtask : t_wide_short
  task t_cal;
    mode = rpq_pkg::RPQ_MODE_RF_CAL;
    {cal, settle} = 2'h3;
    step(1);
    settle = 1'b0;
    thr = 1'b1;
    step(8);
    chk({hold, lat}, 2'h2);
    finish_pulse();
    mode = rpq_pkg::RPQ_MODE_NORMAL;
    cal = 1'b0;
  endtask : t_cal
  task t_both;
    int p0;
    p0 = n_pv;
    {nar_n, wid_n} = 2'h0;
    pulse_up();
    step(500);
    chk({link.narrow_accept, link.wide_accept}, 2'h3);
    chk(n_pv - p0, 16'h0000);
    finish_pulse();
  endtask : t_both
  task results;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  // main sequence; narrow mode first, wide later
  initial begin
    {thr, p95, half, fcmp, fwin, cal, settle, done} = 8'h00;
    {en, blank_n, nar_n, wid_n} = 4'hD;
    mode = rpq_pkg::RPQ_MODE_NORMAL;
    step(2);
    rst_i = 1'b0;
    chk({hold, qs, link.narrow_accept, link.wide_accept}, 4'h3);
    t_gate();
    t_narrow_ok();
    t_narrow_short();
    t_oor();
    t_wide_ok();
    t_wide_short();
    t_cal();
    t_both();
    results();
  end
  // watchdog, well past the expected few thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
endmodule : tb
